/* File: hw/lcr_bank.sv */
// Serial-accessed control and status register bank for three regulators, the keep-alive enable and the push button
// How it works
// - six-bit output level code per regulator
// - control bit 7 switches regulator on/off
// - bit 2 discharges output while shut down
// - bit 1 lets regulator faults interrupt
// - bit 0 reads live power-good level
// - press enable raises interrupt on assertion
// - release enable raises interrupt on release
// - press interrupt sets readable status flag
// - source address byte, 0xff when idle, cleared by its read
module lcr_bank #(
    parameter logic [6:0] DEV_ADDR = lcr_pkg::DEF_DEV_ADDR  // Arbitrary bus address
) (
    input  wire logic                    CLOCK,         // System clock, 100 MHz
    input  wire logic                    RST_B,         // Async reset, active low
    input  wire logic                    SCL,           // Serial clock pin
    input  wire logic                    SDA_IN,        // Serial data pin level
    output wire logic                    SDA_OUT,       // Serial data drive value
    output wire logic                    SDA_OE,        // Serial data pull-low enable
    input  wire logic                    PUSH_BUTTON_B, // Push button, low when pressed
    input  wire logic [2:0]              POWER_GOOD,    // Regulator outputs in range
    input  wire logic [2:0]              FAULT,         // Regulator fault levels
    output wire logic [3:0]              REG_ENABLE,    // Regulator on, bit 3 keep-alive
    output wire logic [2:0]              DISCHARGE_ON,  // Output discharge switches
    output wire lcr_pkg::lcr_levels_type LEVEL_CODE,    // Target level codes
    output wire logic                    IRQ_B          // Interrupt pending, active low
);
    import lcr_pkg::*;

    logic [8:0]    sync1_ff;
    logic [8:0]    sync2_ff;
    logic [8:0]    prev_ff;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_cond;
    logic          stop_cond;
    logic          sda_s;
    logic          pb_assert;
    logic [2:0]    pg_s;
    logic [2:0]    flt_rise;
    lcr_state_type st_ff;
    lcr_state_type nxt_st;
    logic [3:0]    cnt_ff;
    logic [3:0]    nxt_cnt;
    logic [7:0]    sh_ff;
    logic [7:0]    nxt_sh;
    logic [7:0]    tx_ff;
    logic [7:0]    nxt_tx;
    logic [7:0]    ptr_ff;
    logic [7:0]    nxt_ptr;
    logic          rw_ff;
    logic          nxt_rw;
    logic          need_ff;
    logic          nxt_need;
    logic          oe_ff;
    logic          nxt_oe;
    logic          wr_stb;
    logic          rd_load;
    lcr_ldo_type [NUM_LDO-1:0] ldo_ff;
    lcr_ldo_type [NUM_LDO-1:0] nxt_ldo;
    logic          ka_en_ff;
    logic          nxt_ka_en;
    logic          press_en_ff;
    logic          nxt_press_en;
    logic          rel_en_ff;
    logic          nxt_rel_en;
    logic          press_flag_ff;
    logic          nxt_press_flag;
    logic          rel_flag_ff;
    logic          nxt_rel_flag;
    logic [7:0]    src_ff;
    logic [7:0]    nxt_src;
    logic [2:0]    dis_on_ff;
    logic [2:0]    nxt_dis_on;
    logic          irq_b_ff;
    logic          press_evt;
    logic          rel_evt;

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        logic [7:0] d;
        d = RST_BYTE;
        for (int i = 0; i < NUM_LDO; i++)
        begin
            if (a == LEVEL_OFF[i])
                d[LEVEL_W-1:0] = ldo_ff[i].level;
            if (a == CTRL_OFF[i])
            begin
                d[BIT_EN]  = ldo_ff[i].en;
                d[BIT_DIS] = ldo_ff[i].dis;
                d[BIT_FLT] = ldo_ff[i].fault_en;
                d[BIT_PG]  = pg_s[i];
            end
        end
        if (a == OFF_KA_CTRL)
            d[BIT_EN] = ka_en_ff;
        if (a == OFF_BTN_CTRL)
        begin
            d[BIT_PRESS]   = press_en_ff;
            d[BIT_RELEASE] = rel_en_ff;
        end
        if (a == OFF_IRQ_SRC)
            d = src_ff;
        if (a == OFF_BTN_STAT)
        begin
            d[BIT_PRESS]   = press_flag_ff;
            d[BIT_RELEASE] = rel_flag_ff;
            d[BIT_LIVE]    = pb_assert;
        end
        return d;
    endfunction

    // Pins cross in; edges compare the second stage with the third
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sync1_ff <= 9'h1ff;
            sync2_ff <= 9'h1ff;
            prev_ff  <= 9'h1ff;
        end
        else
        begin
            sync1_ff <= {SCL, SDA_IN, PUSH_BUTTON_B, POWER_GOOD, FAULT};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign sda_s      = sync2_ff[7];
    assign scl_rise   = sync2_ff[8] & ~prev_ff[8];
    assign scl_fall   = ~sync2_ff[8] & prev_ff[8];
    assign start_cond = sync2_ff[8] & prev_ff[8] & ~sda_s & prev_ff[7];
    assign stop_cond  = sync2_ff[8] & prev_ff[8] & sda_s & ~prev_ff[7];
    assign pb_assert  = ~sync2_ff[6];
    assign pg_s       = sync2_ff[5:3];

    // Serial slave: address, pointer byte, then data with auto-increment
    always_comb
    begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_sh   = sh_ff;
        nxt_tx   = tx_ff;
        nxt_ptr  = ptr_ff;
        nxt_rw   = rw_ff;
        nxt_need = need_ff;
        wr_stb   = 1'b0;
        rd_load  = 1'b0;
        if (scl_rise)
        begin
            nxt_sh  = {sh_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
        end
        unique case (st_ff)
            ST_IDLE:
                nxt_st = ST_IDLE;
            ST_ADDR:
                if (scl_fall && cnt_ff == BITS_PER_BYTE)
                begin
                    nxt_st   = (sh_ff[7:1] == DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE;
                    nxt_rw   = sh_ff[0];
                    nxt_need = ~sh_ff[0];
                end
            ST_ACK_ADDR:
                if (scl_fall)
                begin
                    nxt_cnt = 4'h0;
                    nxt_st  = rw_ff ? ST_READ : ST_WRITE;
                    if (rw_ff)
                    begin
                        rd_load = 1'b1;
                        nxt_tx  = reg_read(ptr_ff);
                        nxt_ptr = ptr_ff + 8'h01;
                    end
                end
            ST_WRITE:
                if (scl_fall && cnt_ff == BITS_PER_BYTE)
                begin
                    nxt_st   = ST_ACK_WR;
                    nxt_need = 1'b0;
                    wr_stb   = ~need_ff;
                    nxt_ptr  = need_ff ? sh_ff : ptr_ff + 8'h01;
                end
            ST_ACK_WR:
                if (scl_fall)
                begin
                    nxt_cnt = 4'h0;
                    nxt_st  = ST_WRITE;
                end
            ST_READ:
                if (scl_fall)
                begin
                    nxt_tx = {tx_ff[6:0], 1'b0};
                    if (cnt_ff == BITS_PER_BYTE)
                        nxt_st = ST_MACK;
                end
            ST_MACK:
                if (scl_fall)
                begin
                    nxt_cnt = 4'h0;
                    if (sh_ff[0])
                        nxt_st = ST_IDLE;
                    else
                    begin
                        nxt_st  = ST_READ;
                        rd_load = 1'b1;
                        nxt_tx  = reg_read(ptr_ff);
                        nxt_ptr = ptr_ff + 8'h01;
                    end
                end
            default:
                nxt_st = ST_IDLE;
        endcase
        if (start_cond)
        begin
            nxt_st  = ST_ADDR;
            nxt_cnt = 4'h0;
        end
        else if (stop_cond)
            nxt_st = ST_IDLE;
        nxt_oe = (nxt_st == ST_ACK_ADDR) || (nxt_st == ST_ACK_WR) || (nxt_st == ST_READ && !nxt_tx[7]);
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_ff   <= ST_IDLE;
            cnt_ff  <= 4'h0;
            sh_ff   <= RST_BYTE;
            tx_ff   <= RST_BYTE;
            ptr_ff  <= RST_BYTE;
            rw_ff   <= 1'b0;
            need_ff <= 1'b0;
            oe_ff   <= 1'b0;
        end
        else
        begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            sh_ff   <= nxt_sh;
            tx_ff   <= nxt_tx;
            ptr_ff  <= nxt_ptr;
            rw_ff   <= nxt_rw;
            need_ff <= nxt_need;
            oe_ff   <= nxt_oe;
        end
    end

    // Fault edges, and button edges gated by their enables
    assign flt_rise  = sync2_ff[2:0] & ~prev_ff[2:0];
    assign press_evt = pb_assert & prev_ff[6] & press_en_ff;
    assign rel_evt   = ~pb_assert & ~prev_ff[6] & rel_en_ff;

    always_comb
    begin
        nxt_ldo      = ldo_ff;
        nxt_ka_en    = ka_en_ff;
        nxt_press_en = press_en_ff;
        nxt_rel_en   = rel_en_ff;
        nxt_src      = src_ff;
        for (int i = 0; i < NUM_LDO; i++)
        begin
            if (wr_stb && ptr_ff == LEVEL_OFF[i])
                nxt_ldo[i].level = sh_ff[LEVEL_W-1:0];
            if (wr_stb && ptr_ff == CTRL_OFF[i])
            begin
                nxt_ldo[i].en       = sh_ff[BIT_EN];
                nxt_ldo[i].dis      = sh_ff[BIT_DIS];
                nxt_ldo[i].fault_en = sh_ff[BIT_FLT];
            end
            nxt_dis_on[i] = nxt_ldo[i].dis & ~nxt_ldo[i].en;
        end
        if (wr_stb && ptr_ff == OFF_KA_CTRL)
            nxt_ka_en = sh_ff[BIT_EN];
        if (wr_stb && ptr_ff == OFF_BTN_CTRL)
        begin
            nxt_press_en = sh_ff[BIT_PRESS];
            nxt_rel_en   = sh_ff[BIT_RELEASE];
        end
        // press flag, set beats read clear
        nxt_press_flag = press_evt | (press_flag_ff & ~(rd_load && ptr_ff == OFF_BTN_STAT));
        nxt_rel_flag   = rel_evt | (rel_flag_ff & ~(rd_load && ptr_ff == OFF_BTN_STAT));
        if (rd_load && ptr_ff == OFF_IRQ_SRC)
            nxt_src = SRC_NONE;
        // First source holds until read; button outranks faults
        if (nxt_src == SRC_NONE)
        begin
            for (int i = NUM_LDO - 1; i >= 0; i--)
                if (flt_rise[i] && ldo_ff[i].fault_en)
                    nxt_src = CTRL_OFF[i];
            if (press_evt || rel_evt)
                nxt_src = OFF_BTN_CTRL;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ldo_ff        <= '0;
            ka_en_ff      <= 1'b0;
            press_en_ff   <= 1'b0;
            rel_en_ff     <= 1'b0;
            press_flag_ff <= 1'b0;
            rel_flag_ff   <= 1'b0;
            src_ff        <= SRC_NONE;
            dis_on_ff     <= 3'h0;
            irq_b_ff      <= 1'b1;
        end
        else
        begin
            ldo_ff        <= nxt_ldo;
            ka_en_ff      <= nxt_ka_en;
            press_en_ff   <= nxt_press_en;
            rel_en_ff     <= nxt_rel_en;
            press_flag_ff <= nxt_press_flag;
            rel_flag_ff   <= nxt_rel_flag;
            src_ff        <= nxt_src;
            dis_on_ff     <= nxt_dis_on;
            irq_b_ff      <= (nxt_src == SRC_NONE);
        end
    end

    assign SDA_OUT      = 1'b0;
    assign SDA_OE       = oe_ff;
    assign REG_ENABLE   = {ka_en_ff, ldo_ff[2].en, ldo_ff[1].en, ldo_ff[0].en};
    assign DISCHARGE_ON = dis_on_ff;
    assign IRQ_B        = irq_b_ff;
    for (genvar g = 0; g < NUM_LDO; g++)
    begin : g_lvl
        assign LEVEL_CODE[g] = ldo_ff[g].level;
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    a_level_store: assert property (wr_stb && ptr_ff == OFF_L10_LEVEL |=> LEVEL_CODE[0] == $past(sh_ff[5:0]))
        else $error("level code not stored");
    a_enable_pin: assert property (wr_stb && ptr_ff == OFF_L11_CTRL |=> REG_ENABLE[1] == $past(sh_ff[7]))
        else $error("enable bit did not reach output");
    a_discharge_off: assert property (REG_ENABLE[0] |-> !DISCHARGE_ON[0])
        else $error("discharge active while regulator on");
    a_fault_masked: assert property ($changed(src_ff) && src_ff == OFF_L10_CTRL |-> $past(ldo_ff[0].fault_en))
        else $error("masked fault raised interrupt");
    a_power_good: assert property ($rose(POWER_GOOD[0]) ##1 $stable(POWER_GOOD[0]) [*2] |->
        (reg_read(OFF_L10_CTRL) & 8'h01) == 8'h01)
        else $error("power good not visible");
    a_press_flag: assert property (press_evt |=> press_flag_ff ##1 1'b1)
        else $error("press did not set flag");
    a_release_src: assert property (rel_evt && src_ff == SRC_NONE |=> src_ff == OFF_BTN_CTRL && !IRQ_B)
        else $error("release interrupt missing");
    a_flag_cause: assert property ($rose(press_flag_ff) |-> $past(press_en_ff) && $past(pb_assert))
        else $error("press flag without enabled press");
    a_src_clear: assert property (rd_load && ptr_ff == OFF_IRQ_SRC && !press_evt && !rel_evt && flt_rise == 3'h0
        |=> src_ff == SRC_NONE ##1 1'b1)
        else $error("source byte not returned to idle");
    a_reserved_zero: assert property ((reg_read(OFF_KA_CTRL) & 8'h7f) == 8'h00
        && (reg_read(OFF_BTN_CTRL) & 8'h3f) == 8'h00 && (reg_read(OFF_L12_CTRL) & 8'h78) == 8'h00)
        else $error("reserved bits not zero");

    c_write_done: cover property (wr_stb ##[1:40] st_ff == ST_ACK_WR);
    c_read_src: cover property (rd_load && ptr_ff == OFF_IRQ_SRC && src_ff != SRC_NONE);
    c_fault_irq: cover property (flt_rise[2] && ldo_ff[2].fault_en ##1 !IRQ_B);
endmodule

/* File: hw/lcr_pkg.sv */
// Shared constants and types for the regulator control register bank
package lcr_pkg;
    localparam int             NUM_LDO        = 3;
    localparam int             LEVEL_W        = 6;
    // Register byte addresses
    localparam logic [7:0]     OFF_L10_LEVEL  = 8'h80;
    localparam logic [7:0]     OFF_L10_CTRL   = 8'h81;
    localparam logic [7:0]     OFF_L11_LEVEL  = 8'h90;
    localparam logic [7:0]     OFF_L11_CTRL   = 8'h91;
    localparam logic [7:0]     OFF_L12_LEVEL  = 8'ha0;
    localparam logic [7:0]     OFF_L12_CTRL   = 8'ha1;
    localparam logic [7:0]     OFF_KA_CTRL    = 8'hb1;
    localparam logic [7:0]     OFF_BTN_CTRL   = 8'hc0;
    localparam logic [7:0]     OFF_IRQ_SRC    = 8'hc1;
    localparam logic [7:0]     OFF_BTN_STAT   = 8'hc2;
    localparam logic [NUM_LDO-1:0][7:0] LEVEL_OFF = {OFF_L12_LEVEL, OFF_L11_LEVEL, OFF_L10_LEVEL};
    localparam logic [NUM_LDO-1:0][7:0] CTRL_OFF  = {OFF_L12_CTRL, OFF_L11_CTRL, OFF_L10_CTRL};
    // Field positions
    localparam int             BIT_EN         = 7;
    localparam int             BIT_DIS        = 2;
    localparam int             BIT_FLT        = 1;
    localparam int             BIT_PG         = 0;
    localparam int             BIT_PRESS      = 7;
    localparam int             BIT_RELEASE    = 6;
    localparam int             BIT_LIVE       = 5;
    // Reset values and bus constants
    localparam logic [7:0]     SRC_NONE       = 8'hff;
    localparam logic [7:0]     RST_BYTE       = 8'h00;
    localparam logic [3:0]     BITS_PER_BYTE  = 4'h8;
    localparam logic [6:0]     DEF_DEV_ADDR   = 7'h5a;

    typedef struct packed {
        logic               en;
        logic               dis;
        logic               fault_en;
        logic [LEVEL_W-1:0] level;
    } lcr_ldo_type;

    typedef logic [NUM_LDO-1:0][LEVEL_W-1:0] lcr_levels_type;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ACK_ADDR = 3'h3,
        ST_WRITE    = 3'h2,
        ST_ACK_WR   = 3'h6,
        ST_READ     = 3'h7,
        ST_MACK     = 3'h5
    } lcr_state_type;
endpackage

/* File: verif/lcr_bank_test.sv */
// Self-checking bench for the regulator control register bank
module lcr_bank_test;
    timeunit 1ns;
    timeprecision 100ps;
    import lcr_pkg::*;

    localparam logic [6:0] BUS_ADDR = 7'h3c;
    logic           CLOCK, RST_B, PUSH_BUTTON_B, SDA_OUT, SDA_OE, IRQ_B, scl, sda_pull;
    logic [2:0]     POWER_GOOD, FAULT, DISCHARGE_ON;
    logic [3:0]     REG_ENABLE;
    lcr_levels_type LEVEL_CODE;
    wire logic      sda_line = !(sda_pull || SDA_OE);
    int             mismatches = 0;
    int             checked = 0;

    lcr_bank #(.DEV_ADDR(BUS_ADDR)) i_lcr_bank (.CLOCK(CLOCK), .RST_B(RST_B), .SCL(scl), .SDA_IN(sda_line),
        .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .PUSH_BUTTON_B(PUSH_BUTTON_B), .POWER_GOOD(POWER_GOOD),
        .FAULT(FAULT), .REG_ENABLE(REG_ENABLE), .DISCHARGE_ON(DISCHARGE_ON), .LEVEL_CODE(LEVEL_CODE),
        .IRQ_B(IRQ_B));
    lcr_host i_lcr_host (.clk(CLOCK), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge CLOCK);
        @(negedge CLOCK);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic ack;
        @(posedge CLOCK);
        i_lcr_host.start_cond();
        i_lcr_host.send_byte({BUS_ADDR, 1'b0}, ack);
        i_lcr_host.send_byte(a, ack);
        i_lcr_host.send_byte(d, ack);
        chk(ack, 1'b1, "write ack");
        i_lcr_host.stop_cond();
        settle(4);
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        logic ack;
        @(posedge CLOCK);
        i_lcr_host.start_cond();
        i_lcr_host.send_byte({BUS_ADDR, 1'b0}, ack);
        i_lcr_host.send_byte(a, ack);
        i_lcr_host.start_cond();
        i_lcr_host.send_byte({BUS_ADDR, 1'b1}, ack);
        chk(ack, 1'b1, "read address ack");
        i_lcr_host.get_byte(1'b1, d);
        i_lcr_host.stop_cond();
        settle(4);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        reg_rd(a, d);
        chk(d, exp, what);
    endtask

    task automatic t_reset();
        logic ack;
        chk(REG_ENABLE, 4'h0, "enables after reset");
        chk(LEVEL_CODE, '0, "codes after reset");
        chk(IRQ_B, 1'b1, "irq idle");
        chk(SDA_OUT, 1'b0, "data drive value");
        rd_chk(OFF_IRQ_SRC, SRC_NONE, "source idle");
        rd_chk(8'h55, 8'h00, "unmapped read");
        @(posedge CLOCK);
        i_lcr_host.start_cond();
        i_lcr_host.send_byte({BUS_ADDR ^ 7'h01, 1'b0}, ack);
        chk(ack, 1'b0, "foreign address ack");
        i_lcr_host.stop_cond();
        $display("test reset done");
    endtask

    task automatic t_levels();
        logic [7:0] val [3] = '{8'hff, 8'h55, 8'hea};
        for (int i = 0; i < 3; i++)
            reg_wr(LEVEL_OFF[i], val[i]);
        for (int i = 0; i < 3; i++)
        begin
            rd_chk(LEVEL_OFF[i], val[i] & 8'h3f, "level readback");
            chk(LEVEL_CODE[i], val[i][5:0], "level pins");
        end
        $display("test levels done");
    endtask

    task automatic t_ctrl();
        @(posedge CLOCK);
        POWER_GOOD <= 3'b101;
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(CTRL_OFF[i], 8'hff);
            rd_chk(CTRL_OFF[i], {7'h43, POWER_GOOD[i]}, "control all ones");
            chk({REG_ENABLE[i], DISCHARGE_ON[i]}, 2'b10, "on, no discharge");
            reg_wr(CTRL_OFF[i], 8'h04);
            chk({REG_ENABLE[i], DISCHARGE_ON[i]}, 2'b01, "off, discharging");
            rd_chk(CTRL_OFF[i], {7'h02, POWER_GOOD[i]}, "discharge only");
            reg_wr(CTRL_OFF[i], 8'h00);
            chk(DISCHARGE_ON[i], 1'b0, "discharge off");
        end
        @(posedge CLOCK);
        POWER_GOOD <= 3'b010;
        // Expectation reads the driven level, so let it land first
        settle(1);
        for (int i = 0; i < 3; i++)
            rd_chk(CTRL_OFF[i], {7'h00, POWER_GOOD[i]}, "power good follows");
        reg_wr(OFF_KA_CTRL, 8'hff);
        rd_chk(OFF_KA_CTRL, 8'h80, "keep-alive readback");
        chk(REG_ENABLE, 4'h8, "keep-alive on alone");
        reg_wr(OFF_KA_CTRL, 8'h00);
        chk(REG_ENABLE[3], 1'b0, "keep-alive off");
        $display("test control done");
    endtask

    // One frame writes two registers, a second reads both back
    task automatic t_burst();
        logic       ack;
        logic [7:0] d0;
        logic [7:0] d1;
        @(posedge CLOCK);
        i_lcr_host.start_cond();
        i_lcr_host.send_byte({BUS_ADDR, 1'b0}, ack);
        i_lcr_host.send_byte(OFF_L10_LEVEL, ack);
        i_lcr_host.send_byte(8'h6c, ack);
        i_lcr_host.send_byte(8'h80, ack);
        chk(ack, 1'b1, "burst write ack");
        i_lcr_host.stop_cond();
        settle(4);
        @(posedge CLOCK);
        i_lcr_host.start_cond();
        i_lcr_host.send_byte({BUS_ADDR, 1'b0}, ack);
        i_lcr_host.send_byte(OFF_L10_LEVEL, ack);
        i_lcr_host.start_cond();
        i_lcr_host.send_byte({BUS_ADDR, 1'b1}, ack);
        i_lcr_host.get_byte(1'b0, d0);
        i_lcr_host.get_byte(1'b1, d1);
        i_lcr_host.stop_cond();
        settle(4);
        chk(d0, 8'h2c, "burst level");
        chk(d1, 8'h80, "burst control");
        chk(REG_ENABLE, 4'h1, "burst enable");
        chk(LEVEL_CODE[0], 6'h2c, "burst level pin");
        $display("test burst done");
    endtask

    task automatic t_fault();
        @(posedge CLOCK);
        FAULT <= 3'b010;
        settle(10);
        chk(IRQ_B, 1'b1, "masked fault");
        @(posedge CLOCK);
        FAULT <= 3'b000;
        reg_wr(OFF_L11_CTRL, 8'h02);
        @(posedge CLOCK);
        FAULT <= 3'b010;
        settle(10);
        chk(IRQ_B, 1'b0, "enabled fault");
        rd_chk(OFF_IRQ_SRC, OFF_L11_CTRL, "fault source");
        rd_chk(OFF_IRQ_SRC, SRC_NONE, "source cleared by read");
        chk(IRQ_B, 1'b1, "irq cleared");
        @(posedge CLOCK);
        FAULT <= 3'b000;
        reg_wr(OFF_L10_CTRL, 8'h02);
        reg_wr(OFF_L12_CTRL, 8'h02);
        @(posedge CLOCK);
        FAULT <= 3'b100;
        settle(10);
        rd_chk(OFF_IRQ_SRC, OFF_L12_CTRL, "fault source twelve");
        @(posedge CLOCK);
        FAULT <= 3'b101;
        settle(10);
        chk(IRQ_B, 1'b0, "fault ten irq");
        rd_chk(OFF_IRQ_SRC, OFF_L10_CTRL, "fault source ten");
        @(posedge CLOCK);
        FAULT <= 3'b000;
        $display("test fault done");
    endtask

    task automatic push(input logic level);
        @(posedge CLOCK);
        PUSH_BUTTON_B <= level;
        settle(10);
    endtask

    task automatic t_button();
        reg_wr(OFF_BTN_CTRL, 8'hff);
        rd_chk(OFF_BTN_CTRL, 8'hc0, "button enables");
        push(1'b0);
        chk(IRQ_B, 1'b0, "press irq");
        rd_chk(OFF_IRQ_SRC, OFF_BTN_CTRL, "press source");
        rd_chk(OFF_BTN_STAT, 8'ha0, "press flag");
        push(1'b1);
        chk(IRQ_B, 1'b0, "release irq");
        rd_chk(OFF_IRQ_SRC, OFF_BTN_CTRL, "release source");
        rd_chk(OFF_BTN_STAT, 8'h40, "release flag");
        reg_wr(OFF_BTN_CTRL, 8'h80);
        push(1'b0);
        rd_chk(OFF_IRQ_SRC, OFF_BTN_CTRL, "press only source");
        push(1'b1);
        chk(IRQ_B, 1'b1, "release masked");
        rd_chk(OFF_BTN_STAT, 8'h80, "press flag only");
        $display("test button done");
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    // Whole run takes about 38k cycles
    initial
    begin
        #700us;
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end

    initial
    begin
        RST_B = 1'b0;
        PUSH_BUTTON_B = 1'b1;
        POWER_GOOD = 3'b000;
        FAULT = 3'b000;
        repeat (6) @(posedge CLOCK);
        RST_B <= 1'b1;
        settle(6);
        t_reset();
        t_levels();
        t_ctrl();
        t_burst();
        t_fault();
        t_button();
        close_out();
    end
endmodule

/* File: verif/lcr_host.sv */
// Host processor model driving the serial register pins
module lcr_host (
    input  wire logic clk,      // Bench clock
    input  wire logic sda_line, // Resolved data wire
    output logic      scl,      // Serial clock, host only
    output logic      sda_pull  // High while host pulls data low
);
    timeunit 1ns;
    timeprecision 100ps;
    // Above the eight-cycle minimum phase
    localparam int PHASE = 10;

    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Start or repeated start, leaves the clock low
    task automatic start_cond();
        sda_pull <= 1'b0;
        wait_clk(PHASE);
        scl <= 1'b1;
        wait_clk(PHASE);
        sda_pull <= 1'b1;
        wait_clk(PHASE);
        scl <= 1'b0;
        wait_clk(2);
    endtask

    task automatic stop_cond();
        sda_pull <= 1'b1;
        wait_clk(PHASE);
        scl <= 1'b1;
        wait_clk(PHASE);
        sda_pull <= 1'b0;
        wait_clk(PHASE);
    endtask

    // Data moves two cycles after the clock fall, never with it
    task automatic clock_bit(input logic tx, output logic rx);
        sda_pull <= !tx;
        wait_clk(PHASE);
        scl <= 1'b1;
        wait_clk(PHASE / 2);
        @(negedge clk);
        rx = sda_line;
        wait_clk(PHASE / 2);
        scl <= 1'b0;
        wait_clk(2);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic rx;
        for (int i = 7; i >= 0; i--)
            clock_bit(d[i], rx);
        clock_bit(1'b1, rx);
        ack = !rx;
    endtask

    // Last byte of a read answered with a release
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic rx;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(1'b1, rx);
            d[i] = rx;
        end
        clock_bit(last, rx);
    endtask
endmodule
